// *** verilog/burst2_pkg.sv ***
// Purpose: shared constants for the two-beat DDR static memory link
// Assumes: one system clock; the controller end makes the link clocks
// Notes: latencies are counted in link half-cycles (K and K# rising edges)
package burst2_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;          // one data beat
  localparam int LANE_W = 9;           // one byte lane with its extra bit
  localparam int LANES = DATA_W / LANE_W;
  localparam int ADDR_W = 20;          // burst address, two words each
  localparam int BEATS = 2;            // fixed burst length
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 25;   // sys_clk at 40 MHz
  localparam int K_PERIOD_NS = 200;    // link clock pair period
  localparam int K_HALF_CYC = K_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int LAT_DLL_ON = 5;       // first beat 2.5 cycles after command
  localparam int LAT_DLL_OFF = 3;      // bypass mode, one cycle shorter
  localparam int PIPE_LEN = LAT_DLL_ON + 1;
  // ----------------------------------------------------------------
  // buffering and reset values
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam logic ECHO_TRUE_RST = 1'b0;
  localparam logic ECHO_COMP_RST = 1'b1;
endpackage : burst2_pkg

// *** verilog/sram_link_if.sv ***
// Purpose: pin bundle between memory controller and memory
// Assumes: all signals are plain levels; no two-way pins
// Notes: ctrl modport drives clocks, commands and write data
`timescale 1ns/1ps
`default_nettype none
interface sram_link_if;
  import burst2_pkg::*;
  logic kClk;                          // true input clock
  logic kClkN;                         // complementary input clock
  logic rdSelN;                        // read select, active low
  logic wrSelN;                        // write select, active low
  logic [ADDR_W-1:0] addressIn;        // read addr on K, write addr on K#
  logic [DATA_W-1:0] dataIn;           // write beats
  logic [LANES-1:0] byteLaneMaskN;     // low lets a lane be written
  logic doffN;                         // low bypasses the delay loop
  logic [DATA_W-1:0] readData;         // read beats
  logic echoOutTrue;                   // echo clock
  logic echoOutComp;                   // echo clock, inverted
  logic readValidFlag;                 // read beat valid
  modport ctrl (
    output kClk, kClkN, rdSelN, wrSelN, addressIn, dataIn, byteLaneMaskN, doffN,
    input readData, echoOutTrue, echoOutComp, readValidFlag
  );
  modport mem (
    input kClk, kClkN, rdSelN, wrSelN, addressIn, dataIn, byteLaneMaskN, doffN,
    output readData, echoOutTrue, echoOutComp, readValidFlag
  );
endinterface : sram_link_if
`default_nettype wire

// *** verilog/burst2_mem_end.sv ***
// Purpose: memory end of the two-beat DDR static memory link
// Assumes: every link input is asynchronous to sys_clk and is synchronised here
// Notes: link edges are found by sampling K and K# with sys_clk
`timescale 1ns/1ps
`default_nettype none
module burst2_mem_end
  import burst2_pkg::*;
#(
  parameter int MEM_ADDR_W = ADDR_W    // burst address width of the array
) (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // link pins
  sram_link_if.mem link
);
  // ----------------------------------------------------------------
  // local sizes
  // ----------------------------------------------------------------
  localparam int MEM_WORDS = 2 ** (MEM_ADDR_W + 1);  // two words per burst
  localparam int IN_W = 4 + ADDR_W + DATA_W + LANES + 1;
  // idle pin levels: K low, K# high, selects and masks high; a zero reset
  // would show a false K# rise right after reset
  localparam logic [IN_W-1:0] PINS_IDLE = {2'b01, 2'b11, {(ADDR_W + DATA_W){1'b0}},
                                          {LANES{1'b1}}, 1'b0};

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  logic [IN_W-1:0] pinBundle;          // all link inputs side by side
  logic [IN_W-1:0] sync1_q;            // first stage, read only by sync2_q
  logic [IN_W-1:0] sync2_q;            // second stage, safe to use
  logic kPrev_q;                       // K one sample ago
  logic kcPrev_q;                      // K# one sample ago
  logic sK;                            // synchronised K
  logic sKc;                           // synchronised K#
  logic sRdSelN;                       // synchronised read select
  logic sWrSelN;                       // synchronised write select
  logic [ADDR_W-1:0] sAddr;            // synchronised address
  logic [DATA_W-1:0] sData;            // synchronised write data
  logic [LANES-1:0] sMaskN;            // synchronised lane masks
  logic sDoffN;                        // synchronised loop control
  logic kRise;                         // K rising edge seen
  logic kcRise;                        // K# rising edge seen
  logic halfEdge;                      // either link edge

  assign pinBundle = {link.kClk, link.kClkN, link.rdSelN, link.wrSelN,
                      link.addressIn, link.dataIn, link.byteLaneMaskN, link.doffN};
  assign {sK, sKc, sRdSelN, sWrSelN, sAddr, sData, sMaskN, sDoffN} = sync2_q;

  // two flops on every pin; sampling all together keeps data and clock in step
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
    end else begin
      sync1_q <= pinBundle;
      sync2_q <= sync1_q;
    end
  end

  // previous clock samples for edge finding
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      kPrev_q <= 1'b0;
      kcPrev_q <= 1'b1;
    end else begin
      kPrev_q <= sK;
      kcPrev_q <= sKc;
    end
  end

  // only rising edges of each clock time anything
  assign kRise = sK & ~kPrev_q;
  assign kcRise = sKc & ~kcPrev_q;
  assign halfEdge = kRise | kcRise;

  // ----------------------------------------------------------------
  // delay loop mode
  // ----------------------------------------------------------------
  logic dllOn_q;                       // loop running, long latency
  int unsigned lat;                    // first-beat latency in half-cycles

  // mode follows doff; low bypasses and forgets any lock
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dllOn_q <= 1'b0;
    end else begin
      dllOn_q <= sDoffN;
    end
  end

  // latency select; a mode change with reads in flight may skip a beat
  always_comb begin
    if (dllOn_q) begin
      lat = LAT_DLL_ON;
    end else begin
      lat = LAT_DLL_OFF;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:MEM_WORDS-1];  // array, no reset

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  logic wrPend_q;                      // write command taken, address due
  logic [DATA_W-1:0] wrBeat0_q;        // first beat, held in write buffer
  logic [LANES-1:0] wrMask0_q;         // its lane masks
  logic [MEM_ADDR_W:0] wrWord0;        // word address of beat 0
  logic [MEM_ADDR_W:0] wrWord1;        // word address of beat 1

  assign wrWord0 = {sAddr[MEM_ADDR_W-1:0], 1'b0};
  assign wrWord1 = {sAddr[MEM_ADDR_W-1:0], 1'b1};

  // K rise: command and first beat land in the buffer ahead of the address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      wrBeat0_q <= '0;
      wrMask0_q <= '1;
    end else if (kRise) begin
      wrPend_q <= ~sWrSelN;
      if (!sWrSelN) begin
        wrBeat0_q <= sData;
        wrMask0_q <= sMaskN;
      end
    end else if (kcRise) begin
      wrPend_q <= 1'b0;
    end
  end

  // K# rise: address and second beat arrive, both beats commit together
  always_ff @(posedge sys_clk) begin
    if (kcRise && wrPend_q) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wrMask0_q[l]) begin
          mem[wrWord0][l*LANE_W +: LANE_W] <= wrBeat0_q[l*LANE_W +: LANE_W];
        end
        if (!sMaskN[l]) begin
          mem[wrWord1][l*LANE_W +: LANE_W] <= sData[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [PIPE_LEN-1:0] pipeV_q;        // read in flight, per half-cycle slot
  logic [ADDR_W-1:0] pipeA_q [0:PIPE_LEN-1];  // its burst address
  logic beat0Due;                      // first beat goes out this edge
  logic beat1Due;                      // second beat goes out this edge
  logic [MEM_ADDR_W:0] rdWord;         // word to drive
  logic [DATA_W-1:0] readData_q;       // output register
  logic readValid_q;                   // valid flag register

  // a read is loaded on K rise and walks one slot per link edge;
  // the write port has its own state, so both run in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pipeV_q <= '0;
      for (int s = 0; s < PIPE_LEN; s++) begin
        pipeA_q[s] <= '0;
      end
    end else if (halfEdge) begin
      pipeV_q <= {pipeV_q[PIPE_LEN-2:0], kRise & ~sRdSelN};
      pipeA_q[0] <= kRise ? sAddr : pipeA_q[0];
      for (int s = 1; s < PIPE_LEN; s++) begin
        pipeA_q[s] <= pipeA_q[s-1];
      end
    end
  end

  // slot lat-1 before the shift means the command is lat edges old
  assign beat0Due = pipeV_q[lat-1];
  assign beat1Due = pipeV_q[lat];

  // second beat has priority only when both are due; reads load on K rise only, so that never happens
  always_comb begin
    if (beat1Due) begin
      rdWord = {pipeA_q[lat][MEM_ADDR_W-1:0], 1'b1};
    end else begin
      rdWord = {pipeA_q[lat-1][MEM_ADDR_W-1:0], 1'b0};
    end
  end

  // array is read as the beat leaves, so a finished write is always seen
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readData_q <= '0;
      readValid_q <= 1'b0;
    end else if (halfEdge) begin
      if (beat0Due || beat1Due) begin
        readData_q <= mem[rdWord];
      end
      readValid_q <= beat0Due | beat1Due;
    end
  end

  // ----------------------------------------------------------------
  // echo clocks
  // ----------------------------------------------------------------
  logic echoTrue_q;                    // follows K rise/K# rise
  logic echoComp_q;                    // inverse

  // free running; toggled on the same edges that move read data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      echoTrue_q <= ECHO_TRUE_RST;
      echoComp_q <= ECHO_COMP_RST;
    end else if (kRise) begin
      echoTrue_q <= 1'b1;
      echoComp_q <= 1'b0;
    end else if (kcRise) begin
      echoTrue_q <= 1'b0;
      echoComp_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.readData = readData_q;
  assign link.readValidFlag = readValid_q;
  assign link.echoOutTrue = echoTrue_q;
  assign link.echoOutComp = echoComp_q;
endmodule : burst2_mem_end
`default_nettype wire

// *** verilog/burst2_ctrl_end.sv ***
// Purpose: controller end of the two-beat DDR static memory link, with write FIFO
// Assumes: K and K# are made here from sys_clk by a divider
// Notes: link-side inputs pass two flops before use
`timescale 1ns/1ps
`default_nettype none
module burst2_wr_fifo #(
  parameter int WIDTH = 8,             // word width
  parameter int DEPTH = 16             // words held
) (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1]; // word store
  logic [PW-1:0] wrPtr_q;              // next slot to fill
  logic [PW-1:0] rdPtr_q;              // next slot to drain
  logic [PW:0] count_q;                // words held
  logic push;                          // word accepted
  logic pop;                           // word leaves

  assign inReady = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = store[rdPtr_q];

  // pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) store[wrPtr_q] <= inData;
  end
endmodule : burst2_wr_fifo

module burst2_ctrl_end
  import burst2_pkg::*;
#(
  parameter int HALF_CYC = K_HALF_CYC, // sys cycles per link half-cycle
  parameter int DEPTH = FIFO_DEPTH     // write FIFO depth
) (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // write requests, one burst each
  input wire logic wrReqValid,
  output logic wrReqReady,
  input wire logic [ADDR_W-1:0] wrReqAddr,
  input wire logic [DATA_W-1:0] wrReqData0,
  input wire logic [DATA_W-1:0] wrReqData1,
  input wire logic [LANES-1:0] wrReqEn0,
  input wire logic [LANES-1:0] wrReqEn1,
  // read requests
  input wire logic rdReqValid,
  output logic rdReqReady,
  input wire logic [ADDR_W-1:0] rdReqAddr,
  // mode
  input wire logic dllEnable,
  // read beats back
  output logic rdDataValid,
  output logic [DATA_W-1:0] rdData,
  output logic rdDataBeat,
  // link pins
  sram_link_if.ctrl link
);
  // ----------------------------------------------------------------
  // link clock divider
  // ----------------------------------------------------------------
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam int FW = ADDR_W + 2 * DATA_W + 2 * LANES;
  logic [CW-1:0] div_q;                // half-cycle counter
  logic kClk_q;                        // true clock level
  logic tick;                          // half-cycle boundary
  logic midHalf;                       // middle of a half-cycle
  logic launchLow;                     // mid K-low: launch K-rise items
  logic launchHigh;                    // mid K-high: launch K#-rise items

  assign tick = (div_q == CW'(HALF_CYC - 1));
  // pins move mid half-cycle; moving them on a K edge would race the
  // memory end, which samples clock and pins with the same flops
  assign midHalf = (div_q == CW'(HALF_CYC / 2 - 1));
  assign launchLow = midHalf & ~kClk_q;
  assign launchHigh = midHalf & kClk_q;

  // K and K# always run as an exact complementary pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_q <= '0;
      kClk_q <= 1'b0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      if (tick) kClk_q <= ~kClk_q;
    end
  end

  // ----------------------------------------------------------------
  // write FIFO and read request holding
  // ----------------------------------------------------------------
  logic fifoValid;                     // burst waiting
  logic [FW-1:0] fifoData;             // waiting burst
  logic rdPend_q;                      // read request held
  logic [ADDR_W-1:0] rdAddr_q;         // its address

  // drained once per K cycle, so a busy link really fills it
  burst2_wr_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) wrFifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .inValid(wrReqValid),
    .inReady(wrReqReady),
    .inData({wrReqAddr, wrReqData0, wrReqData1, wrReqEn0, wrReqEn1}),
    .outValid(fifoValid),
    .outReady(launchLow),
    .outData(fifoData)
  );

  // refused in the launch cycle so a new request never meets the clear
  assign rdReqReady = ~rdPend_q & ~launchLow;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdPend_q <= 1'b0;
      rdAddr_q <= '0;
    end else if (rdReqValid && rdReqReady) begin
      rdPend_q <= 1'b1;
      rdAddr_q <= rdReqAddr;
    end else if (launchLow) begin
      rdPend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin launch: K-rise items set mid K-low, K#-rise items mid K-high
  // ----------------------------------------------------------------
  logic rdSelN_q, wrSelN_q, doffN_q;
  logic [ADDR_W-1:0] addr_q, wrAddr_q;
  logic [DATA_W-1:0] data_q, beat1_q;
  logic [LANES-1:0] maskN_q, mask1N_q;

  // a quarter link cycle of setup and of hold on every launched pin
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdSelN_q <= 1'b1;
      wrSelN_q <= 1'b1;
      doffN_q <= 1'b0;
      addr_q <= '0;
      wrAddr_q <= '0;
      data_q <= '0;
      beat1_q <= '0;
      maskN_q <= '1;
      mask1N_q <= '1;
    end else if (launchLow) begin
      doffN_q <= dllEnable;
      rdSelN_q <= ~rdPend_q;
      wrSelN_q <= ~fifoValid;
      addr_q <= rdAddr_q;
      {wrAddr_q, data_q, beat1_q, maskN_q, mask1N_q} <=
        {fifoData[FW-1 -: ADDR_W+2*DATA_W], ~fifoData[2*LANES-1 -: 2*LANES]};
    end else if (launchHigh) begin
      addr_q <= wrAddr_q;
      data_q <= beat1_q;
      maskN_q <= mask1N_q;
    end
  end

  assign link.kClk = kClk_q;
  assign link.kClkN = ~kClk_q;
  assign link.rdSelN = rdSelN_q;
  assign link.wrSelN = wrSelN_q;
  assign link.addressIn = addr_q;
  assign link.dataIn = data_q;
  assign link.byteLaneMaskN = maskN_q;
  assign link.doffN = doffN_q;

  // ----------------------------------------------------------------
  // read capture on echo clock edges
  // ----------------------------------------------------------------
  logic [DATA_W+1:0] cap1_q, cap2_q;   // two-flop sampler of echo, valid, data
  logic echoPrev_q;                    // echo one sample ago
  logic beatNext_q;                    // index of next beat
  logic echoEdge;                      // any echo transition

  assign echoEdge = cap2_q[DATA_W+1] ^ echoPrev_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cap1_q <= '0;
      cap2_q <= '0;
      echoPrev_q <= 1'b0;
    end else begin
      cap1_q <= {link.echoOutTrue, link.readValidFlag, link.readData};
      cap2_q <= cap1_q;
      echoPrev_q <= cap2_q[DATA_W+1];
    end
  end

  // beats pair up in order: 0 then 1
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdDataValid <= 1'b0;
      rdData <= '0;
      rdDataBeat <= 1'b0;
      beatNext_q <= 1'b0;
    end else begin
      rdDataValid <= echoEdge & cap2_q[DATA_W];
      if (echoEdge && cap2_q[DATA_W]) begin
        rdData <= cap2_q[DATA_W-1:0];
        rdDataBeat <= beatNext_q;
        beatNext_q <= ~beatNext_q;
      end else if (echoEdge) begin
        beatNext_q <= 1'b0;
      end
    end
  end
endmodule : burst2_ctrl_end
`default_nettype wire

// *** testbench/burst2_link_chk.sv ***
// Purpose: timing checks on the pins between the two link ends
// Assumes: sys_clk samples every pin; link clocks come from sys_clk
// Notes: latency windows include the pin synchroniser delay
`timescale 1ns/1ps
`default_nettype none
module burst2_link_chk
  import burst2_pkg::*;
(
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // controller to memory
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic rdSelN,
  input wire logic wrSelN,
  input wire logic [ADDR_W-1:0] addressIn,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [LANES-1:0] byteLaneMaskN,
  input wire logic doffN,
  // memory to controller
  input wire logic [DATA_W-1:0] readData,
  input wire logic echoOutTrue,
  input wire logic echoOutComp,
  input wire logic readValidFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // command side
  // ----------------------------------------
  a_clk_pair: assert property (kClkN == ~kClk)
    else $error("link clocks not complementary");
  a_rdsel_setup: assert property ($changed(rdSelN) |-> !kClk)
    else $error("read select moved across the true clock rise");
  a_wrsel_setup: assert property ($changed(wrSelN) |-> !kClk)
    else $error("write select moved across the true clock rise");
  a_addr_edge: assert property ($changed(addressIn) |-> $stable(kClk))
    else $error("address moved on a link clock edge");
  a_beat_edge: assert property ($changed(dataIn) || $changed(byteLaneMaskN) |-> $stable(kClk))
    else $error("write beat moved on a link clock edge");
  // ----------------------------------------
  // return side
  // ----------------------------------------
  a_echo_pair: assert property (echoOutComp == ~echoOutTrue)
    else $error("echo clocks not complementary");
  a_data_echo: assert property ($changed(readData) |-> $changed(echoOutTrue))
    else $error("read data moved without an echo edge");
  a_valid_echo: assert property ($rose(readValidFlag) |-> $fell(echoOutTrue))
    else $error("valid rose off the complementary edge");
  a_valid_two: assert property ($rose(readValidFlag) |-> readValidFlag [*8])
    else $error("valid shorter than two beats");
  // window covers sync delay of the pins plus the output flop
  a_lat_dll: assert property ($rose(kClk) && !rdSelN && doffN |-> ##[20:30] $rose(readValidFlag))
    else $error("read latency wrong with loop on");
  a_lat_bypass: assert property ($rose(kClk) && !rdSelN && !doffN |-> ##[10:19] $rose(readValidFlag))
    else $error("read latency wrong in bypass");
  c_read: cover property ($rose(readValidFlag));
  c_both: cover property ($rose(kClk) && !wrSelN && !rdSelN);
  c_bypass: cover property (!doffN && $rose(readValidFlag));
endmodule : burst2_link_chk
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: both link ends back to back, driven from the user side
// Assumes: memory array width 6 bits of burst address
// Notes: a model array keyed by address and beat gives expected data
`timescale 1ns/1ps
`default_nettype none
module tb;
  import burst2_pkg::*;
  logic sys_clk, reset, wrReqValid, wrReqReady, rdReqValid, rdReqReady, dllEnable;
  logic [ADDR_W-1:0] wrReqAddr, rdReqAddr;
  logic [DATA_W-1:0] wrReqData0, wrReqData1, rdData;
  logic [LANES-1:0] wrReqEn0, wrReqEn1;
  logic rdDataValid, rdDataBeat, sawFull;
  logic [DATA_W-1:0] model [0:127]; // expected array contents
  int badCount, nTests;
  sram_link_if link ();
  burst2_mem_end #(.MEM_ADDR_W(6)) u_burst2_mem_end (.sys_clk(sys_clk), .reset(reset),
    .link(link.mem));
  burst2_ctrl_end #(.HALF_CYC(4), .DEPTH(FIFO_DEPTH)) u_burst2_ctrl_end (.sys_clk(sys_clk),
    .reset(reset), .wrReqValid(wrReqValid), .wrReqReady(wrReqReady), .wrReqAddr(wrReqAddr),
    .wrReqData0(wrReqData0), .wrReqData1(wrReqData1), .wrReqEn0(wrReqEn0),
    .wrReqEn1(wrReqEn1), .rdReqValid(rdReqValid), .rdReqReady(rdReqReady),
    .rdReqAddr(rdReqAddr), .dllEnable(dllEnable), .rdDataValid(rdDataValid),
    .rdData(rdData), .rdDataBeat(rdDataBeat), .link(link.ctrl));
  burst2_link_chk u_chk (.sys_clk(sys_clk), .reset(reset), .kClk(link.kClk),
    .kClkN(link.kClkN), .rdSelN(link.rdSelN), .wrSelN(link.wrSelN),
    .addressIn(link.addressIn), .dataIn(link.dataIn), .byteLaneMaskN(link.byteLaneMaskN),
    .doffN(link.doffN), .readData(link.readData), .echoOutTrue(link.echoOutTrue),
    .echoOutComp(link.echoOutComp), .readValidFlag(link.readValidFlag));
  // ----------------------------------------
  // compare, verdict and user-side tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic giveVerdict();
    if (badCount == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : giveVerdict
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
    input logic [LANES-1:0] en);
    merge = o;
    for (int i = 0; i < LANES; i++) if (en[i]) merge[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
  endfunction : merge
  // model updated at entry so a forked read sees it at once
  task automatic wr(input logic [5:0] a, input logic [DATA_W-1:0] d0, d1,
    input logic [LANES-1:0] e0, e1);
    int n;
    model[{a, 1'b0}] = merge(model[{a, 1'b0}], d0, e0);
    model[{a, 1'b1}] = merge(model[{a, 1'b1}], d1, e1);
    @(negedge sys_clk);
    {wrReqValid, wrReqAddr, wrReqData0, wrReqData1} = {1'b1, ADDR_W'(a), d0, d1};
    {wrReqEn0, wrReqEn1} = {e0, e1};
    n = 0;
    while (wrReqReady !== 1'b1 && n < 300) begin
      sawFull = 1'b1;
      n++;
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
    wrReqValid = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    int n;
    @(negedge sys_clk);
    {rdReqValid, rdReqAddr} = {1'b1, ADDR_W'(a)};
    n = 0;
    while (rdReqReady !== 1'b1 && n < 200) begin n++; @(negedge sys_clk); end
    @(negedge sys_clk);
    rdReqValid = 1'b0;
    for (int b = 0; b < BEATS; b++) begin
      while (rdDataValid !== 1'b1 && n < 400) begin n++; @(negedge sys_clk); end
      check("rdDataBeat", DATA_W'(rdDataBeat), DATA_W'(b));
      check("rdData", rdData, model[{a, b[0]}]);
      @(negedge sys_clk);
    end
    check("rdWait", DATA_W'(n < 400), DATA_W'(1));
  endtask : rd
  // ----------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    giveVerdict();
  end
  initial begin
    {reset, wrReqValid, rdReqValid, dllEnable, sawFull} = 5'h12;
    {wrReqAddr, rdReqAddr, wrReqData0, wrReqData1, wrReqEn0, wrReqEn1} = '0;
    {badCount, nTests} = '0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) reset = 1'b0;
    // fill the write buffer past its depth, then read all back
    for (int i = 0; i < 24; i++) wr(6'(i), 18'h2a000 ^ 18'(i), 18'h15000 ^ 18'(i), 2'h3, 2'h3);
    check("sawFull", DATA_W'(sawFull), DATA_W'(1));
    for (int i = 0; i < 24; i++) rd(6'(i));
    // every lane mask pattern on both beats
    for (int e = 0; e < 4; e++) begin
      wr(6'(32 + e), 18'h3ffff, 18'h3ffff, 2'h3, 2'h3);
      wr(6'(32 + e), 18'h0, 18'h0, e[1:0], ~e[1:0]);
      rd(6'(32 + e));
    end
    // read and write of one burst in the same link cycle
    fork
      wr(6'h32, 18'h0c3c3, 18'h13c3c, 2'h3, 2'h3);
      rd(6'h32);
    join
    // bypass mode, then back with the loop on
    @(negedge sys_clk) dllEnable = 1'b0;
    repeat (16) @(negedge sys_clk);
    wr(6'h3c, 18'h01234, 18'h3edcb, 2'h3, 2'h3);
    rd(6'h3c);
    dllEnable = 1'b1;
    repeat (16) @(negedge sys_clk);
    rd(6'h3c);
    // second reset keeps array contents
    reset = 1'b1;
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    repeat (16) @(negedge sys_clk);
    rd(6'h32);
    giveVerdict();
  end
endmodule : tb
`default_nettype wire
